// ### rtl/pb_share_defines.svh
// Register offsets, field positions and reset values for the shared port B pins
`ifndef PB_SHARE_DEFINES_SVH
`define PB_SHARE_DEFINES_SVH

`define PB_ADDR_W        8
`define PB_DATA_W        8
`define PB_DATA_ADDR     8'h01
`define PB_DIR_ADDR      8'h05
`define PB_PDI_ADDR      8'h11
`define PB_SCR_ADDR      8'h0A
`define PB_SHARED_LSB    5
`define PB_SHARED_MSB    7
`define PB_SHARED_N      3
`define PB_SCR_SPE_BIT   6
`define PB_SCR_MASTER_SELECT_BIT_BIT  4
`define PB_DIR_RST       3'h0
`define PB_LATCH_RST     3'h0
`define PB_PDI_RST       3'h0
`define PB_READ_ZERO     8'h00
`define PB_SYNC_RST      3'h0

`endif

// ### rtl/pb_share_pkg.sv
// Types shared by the port B pin-sharing logic
package pb_share_pkg;

    typedef enum logic [1:0] {
        ROLE_DATA_OUT = 2'b00,
        ROLE_DATA_IN  = 2'b01,
        ROLE_CLOCK    = 2'b10
    } pin_role_t;

    typedef struct packed {
        logic serial_enable_bit;
        logic master_select_bit;
    } serial_ctrl_t;

    typedef struct packed {
        logic dir;
        logic latch;
        logic pdi;
    } pin_cfg_t;

    typedef struct packed {
        logic oe;
        logic out;
        logic pd_on;
        logic rd;
    } pin_ctl_t;

endpackage

// ### rtl/shared_pin_cell.sv
// Ownership selection for one shared port pin
module shared_pin_cell
    import pb_share_pkg::*;
#(
    parameter pin_role_t ROLE = ROLE_DATA_OUT
) (
    input  wire serial_ctrl_t ctrl,
    input  wire pin_cfg_t     cfg,
    input  wire logic         global_pd_off,
    input  wire logic         serial_drive,
    input  wire logic         pin_level,
    output pin_ctl_t          ctl
);

    logic serial_oe;

    always_comb begin
        case (ROLE)
            ROLE_DATA_OUT: serial_oe = 1'b1;
            ROLE_DATA_IN:  serial_oe = 1'b0;
            ROLE_CLOCK:    serial_oe = ctrl.master_select_bit;
            default:       serial_oe = 1'b0;
        endcase
    end

    always_comb begin
        if (ctrl.serial_enable_bit) begin
            ctl.oe  = serial_oe;
            ctl.out = serial_drive;
        end else begin
            ctl.oe  = cfg.dir;
            ctl.out = cfg.latch;
        end
        // Pulldown only on a plain input with no inhibit of any kind
        ctl.pd_on = !ctrl.serial_enable_bit && !cfg.dir && !cfg.pdi && !global_pd_off;
        // Readback ignores ownership: latch when an output, pin otherwise
        ctl.rd    = cfg.dir ? cfg.latch : pin_level;
    end

endmodule

// ### rtl/port_b_serial_pin_sharing.sv
// Pin sharing between port B bits 5..7 and the simple serial port
//
// Local design decisions: the address map and the address-and-strobe port.
`include "pb_share_defines.svh"

module port_b_serial_pin_sharing
    import pb_share_pkg::*;
#(
    parameter int NPINS = `PB_SHARED_N
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic [`PB_ADDR_W-1:0]   reg_addr,
    input  wire logic [`PB_DATA_W-1:0]   reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`PB_DATA_W-1:0]   reg_rdata,
    input  wire logic                    global_pulldown_disable,
    input  wire logic                    serial_data_out,
    input  wire logic                    serial_clk_out,
    output logic                         serial_data_in,
    output logic                         serial_clk_in,
    output serial_ctrl_t                 serial_ctrl,
    input  wire logic [NPINS-1:0]        pin_in,
    output logic      [NPINS-1:0]        pin_out,
    output logic      [NPINS-1:0]        pin_oe,
    output logic      [NPINS-1:0]        pulldown_on
);

    logic [NPINS-1:0] dir_reg;
    logic [NPINS-1:0] dir_next;
    logic [NPINS-1:0] latch_reg;
    logic [NPINS-1:0] latch_next;
    logic [NPINS-1:0] pdi_reg;
    logic [NPINS-1:0] pdi_next;
    serial_ctrl_t     scr_reg;
    serial_ctrl_t     scr_next;
    logic [NPINS-1:0] pin_meta_reg;
    logic [NPINS-1:0] pin_sync_reg;
    logic [NPINS-1:0] cell_oe;
    logic [NPINS-1:0] cell_out;
    logic [NPINS-1:0] cell_pd;
    logic [NPINS-1:0] cell_rd;
    logic [NPINS-1:0] serial_drive;
    logic [`PB_DATA_W-1:0] rd_word;

    assign serial_ctrl = scr_reg;

    // Register write decode
    always_comb begin
        dir_next   = dir_reg;
        latch_next = latch_reg;
        pdi_next   = pdi_reg;
        scr_next   = scr_reg;
        if (reg_wr && reg_addr == `PB_DIR_ADDR) begin
            dir_next = reg_wdata[`PB_SHARED_MSB:`PB_SHARED_LSB];
        end else if (reg_wr && reg_addr == `PB_DATA_ADDR) begin
            latch_next = reg_wdata[`PB_SHARED_MSB:`PB_SHARED_LSB];
        end else if (reg_wr && reg_addr == `PB_PDI_ADDR) begin
            pdi_next = reg_wdata[`PB_SHARED_MSB:`PB_SHARED_LSB];
        end else if (reg_wr && reg_addr == `PB_SCR_ADDR) begin
            scr_next.serial_enable_bit  = reg_wdata[`PB_SCR_SPE_BIT];
            scr_next.master_select_bit = reg_wdata[`PB_SCR_MASTER_SELECT_BIT_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dir_reg <= `PB_DIR_RST;
        end else begin
            dir_reg <= dir_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            latch_reg <= `PB_LATCH_RST;
        end else begin
            latch_reg <= latch_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pdi_reg <= `PB_PDI_RST;
        end else begin
            pdi_reg <= pdi_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scr_reg <= '0;
        end else begin
            scr_reg <= scr_next;
        end
    end

    // Pins are asynchronous to the core; two stages before anything looks
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_meta_reg <= `PB_SYNC_RST;
            pin_sync_reg <= `PB_SYNC_RST;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign serial_drive = {serial_clk_out, 1'b0, serial_data_out};

    // Cells see the next register values, so the registered pin controls
    // change on the same edge as the control bits themselves
    generate
        for (genvar i = 0; i < NPINS; i++) begin : g_pin
            localparam pin_role_t R = (i == 0) ? ROLE_DATA_OUT :
                                      (i == 1) ? ROLE_DATA_IN : ROLE_CLOCK;
            pin_cfg_t cfg;
            pin_ctl_t ctl;
            assign cfg = '{dir: dir_next[i], latch: latch_next[i], pdi: pdi_next[i]};
            shared_pin_cell #(
                .ROLE (R)
            ) u_cell (
                .ctrl          (scr_next),
                .cfg           (cfg),
                .global_pd_off (global_pulldown_disable),
                .serial_drive  (serial_drive[i]),
                .pin_level     (pin_sync_reg[i]),
                .ctl           (ctl)
            );
            assign cell_oe[i]  = ctl.oe;
            assign cell_out[i] = ctl.out;
            assign cell_pd[i]  = ctl.pd_on;
            assign cell_rd[i]  = ctl.rd;
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_oe      <= '0;
            pin_out     <= '0;
            pulldown_on <= '0;
        end else begin
            pin_oe      <= cell_oe;
            pin_out     <= cell_out;
            pulldown_on <= cell_pd;
        end
    end

    // Serial inputs are always fed from the pin; the port ignores the
    // clock input while it is master
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            serial_data_in <= 1'b0;
            serial_clk_in  <= 1'b0;
        end else begin
            serial_data_in <= pin_sync_reg[1];
            serial_clk_in  <= pin_sync_reg[2];
        end
    end

    // Read decode; unmapped addresses and unused bits read as zero
    always_comb begin
        rd_word = `PB_READ_ZERO;
        if (reg_addr == `PB_DATA_ADDR) begin
            rd_word[`PB_SHARED_MSB:`PB_SHARED_LSB] = cell_rd;
        end else if (reg_addr == `PB_DIR_ADDR) begin
            rd_word[`PB_SHARED_MSB:`PB_SHARED_LSB] = dir_reg;
        end else if (reg_addr == `PB_PDI_ADDR) begin
            rd_word[`PB_SHARED_MSB:`PB_SHARED_LSB] = pdi_reg;
        end else if (reg_addr == `PB_SCR_ADDR) begin
            rd_word[`PB_SCR_SPE_BIT]  = scr_reg.serial_enable_bit;
            rd_word[`PB_SCR_MASTER_SELECT_BIT_BIT] = scr_reg.master_select_bit;
        end
    end

    // Read data stand for one cycle only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= `PB_READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_word;
        end else begin
            reg_rdata <= `PB_READ_ZERO;
        end
    end

    // Checks
    sequence spe_clear_s;
        reg_wr && reg_addr == `PB_SCR_ADDR && !reg_wdata[`PB_SCR_SPE_BIT] && scr_reg.serial_enable_bit;
    endsequence

    sequence dir_write_read_s;
        reg_wr && reg_addr == `PB_DIR_ADDR ##1 reg_rd && reg_addr == `PB_DIR_ADDR;
    endsequence

    chk_sdo_drive: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        scr_reg.serial_enable_bit |-> pin_oe[0] && pin_out[0] == $past(serial_data_out) && !pulldown_on[0])
    else $error("bit five not driven by serial data");

    chk_sdi_input: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        scr_reg.serial_enable_bit |-> !pin_oe[1] && !pulldown_on[1])
    else $error("bit six not released as serial input");

    chk_sck_master: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        scr_reg.serial_enable_bit && scr_reg.master_select_bit |-> pin_oe[2] && pin_out[2] == $past(serial_clk_out))
    else $error("bit seven not driving serial clock");

    chk_sck_slave: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        scr_reg.serial_enable_bit && !scr_reg.master_select_bit |-> !pin_oe[2])
    else $error("bit seven driven while slave");

    chk_pd_serial: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        scr_reg.serial_enable_bit |-> pulldown_on == '0)
    else $error("pulldown on while serial owns pins");

    chk_latch_harmless: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        scr_reg.serial_enable_bit && reg_wr && reg_addr == `PB_DATA_ADDR
        |=> pin_oe[0] && pin_out[0] == $past(serial_data_out))
    else $error("latch write disturbed serial data");

    chk_rd_owned: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == `PB_DATA_ADDR && scr_reg.serial_enable_bit
        |=> reg_rdata[`PB_SHARED_MSB:`PB_SHARED_LSB]
            == $past((dir_reg & latch_reg) | (~dir_reg & pin_sync_reg)))
    else $error("owned pin readback wrong");

    chk_release: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        spe_clear_s |=> pin_oe == dir_reg && (pin_out & dir_reg) == (latch_reg & dir_reg))
    else $error("pins did not revert to stored bits");

    chk_gp_output: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !scr_reg.serial_enable_bit |-> pin_oe == dir_reg && pin_out == latch_reg)
    else $error("plain port output wrong");

    chk_pd_output: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pin_oe & pulldown_on) == '0 && (dir_reg & pulldown_on) == '0)
    else $error("pulldown on an output pin");

    chk_pd_input: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        // Pulldowns only come on at the first edge after reset is released
        $past(rst_n) && !scr_reg.serial_enable_bit && !$past(global_pulldown_disable)
        |-> pulldown_on == (~dir_reg & ~pdi_reg))
    else $error("input pulldown not following inhibit");

    chk_dir_access: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        dir_write_read_s |=> reg_rdata[`PB_SHARED_MSB:`PB_SHARED_LSB]
            == $past(reg_wdata[`PB_SHARED_MSB:`PB_SHARED_LSB], 2))
    else $error("direction register readback wrong");

    chk_pd_global: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $past(global_pulldown_disable) |-> pulldown_on == '0)
    else $error("pulldown on under global disable");

    chk_same_edge: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr && reg_addr == `PB_DIR_ADDR && !scr_reg.serial_enable_bit && !reg_rd
        |=> pin_oe == $past(reg_wdata[`PB_SHARED_MSB:`PB_SHARED_LSB]))
    else $error("direction change late on pin");

endmodule

// ### verification/pin_partner.sv
// Model of the external serial party and the wiring on the three shared pins
module pin_partner (
    input  wire logic       core_clk,
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    input  wire logic [2:0] pulldown_on,
    input  wire logic [2:0] ext_en,
    input  wire logic [2:0] ext_val,
    output logic      [2:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] last_level = 3'h0;

    always_ff @(posedge core_clk) begin
        last_level <= pin_in;
    end

    // A floating pin flips every cycle so a stale level never reads as valid
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pulldown_on[i]) begin
                pin_in[i] = 1'b0;
            end else begin
                pin_in[i] = ~last_level[i];
            end
        end
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the shared port B pin logic
`include "pb_share_defines.svh"
module testbench
    import pb_share_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic         core_clk, rst_n, reg_wr, reg_rd, global_pulldown_disable;
    logic         serial_data_out, serial_clk_out, serial_data_in, serial_clk_in;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata;
    logic [2:0]   pin_in, pin_out, pin_oe, pulldown_on, ext_en, ext_val;
    serial_ctrl_t serial_ctrl;
    int           mismatches, samples_checked, cycles;

    port_b_serial_pin_sharing uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .global_pulldown_disable(global_pulldown_disable), .serial_data_out(serial_data_out),
        .serial_clk_out(serial_clk_out), .serial_data_in(serial_data_in),
        .serial_clk_in(serial_clk_in), .serial_ctrl(serial_ctrl), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pulldown_on(pulldown_on));

    pin_partner far_side (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pulldown_on(pulldown_on), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic t_reset;
        chk({5'h00, pin_oe}, 8'h00);
        chk({5'h00, pulldown_on}, 8'h07);
        rd(`PB_DIR_ADDR, 8'h00);
    endtask

    task automatic t_output;
        wr(`PB_DATA_ADDR, 8'hA0);
        wr(`PB_DIR_ADDR, 8'hE0);
        chk({5'h00, pin_oe}, 8'h07);
        chk({5'h00, pin_out}, 8'h05);
        chk({5'h00, pulldown_on}, 8'h00);
        rd(`PB_DATA_ADDR, 8'hA0);
    endtask

    task automatic t_input;
        ext_en  <= 3'b101;
        ext_val <= 3'b101;
        wr(`PB_DIR_ADDR, 8'h00);
        wr(`PB_PDI_ADDR, 8'h80);
        chk({5'h00, pulldown_on}, 8'h03);
        idle(3);
        rd(`PB_DATA_ADDR, 8'hA0);
        global_pulldown_disable <= 1'b1;
        idle(2);
        chk({5'h00, pulldown_on}, 8'h00);
        global_pulldown_disable <= 1'b0;
        idle(2);
        chk({5'h00, pulldown_on}, 8'h03);
    endtask

    task automatic t_master;
        ext_en          <= 3'b000;
        serial_data_out <= 1'b1;
        serial_clk_out  <= 1'b1;
        wr(`PB_DIR_ADDR, 8'hE0);
        wr(`PB_DATA_ADDR, 8'h00);
        wr(`PB_SCR_ADDR, 8'h50);
        chk({5'h00, pin_oe}, 8'h05);
        chk({6'h00, serial_ctrl}, 8'h03);
        idle(1);
        chk({5'h00, pin_out & 3'b101}, 8'h05);
        serial_data_out <= 1'b0;
        serial_clk_out  <= 1'b0;
        wr(`PB_DATA_ADDR, 8'hE0);
        idle(1);
        chk({5'h00, pin_out & 3'b101}, 8'h00);
        chk({5'h00, pin_oe}, 8'h05);
        rd(`PB_DATA_ADDR, 8'hE0);
        rd(`PB_DIR_ADDR, 8'hE0);
    endtask

    task automatic t_slave;
        serial_data_out <= 1'b1;
        ext_en  <= 3'b110;
        ext_val <= 3'b110;
        wr(`PB_DIR_ADDR, 8'h00);
        wr(`PB_PDI_ADDR, 8'h00);
        wr(`PB_SCR_ADDR, 8'h40);
        chk({5'h00, pin_oe}, 8'h01);
        chk({5'h00, pulldown_on}, 8'h00);
        idle(4);
        chk({6'h00, serial_data_in, serial_clk_in}, 8'h03);
        rd(`PB_DATA_ADDR, 8'hE0);
        ext_val <= 3'b000;
        idle(4);
        chk({6'h00, serial_data_in, serial_clk_in}, 8'h00);
        rd(`PB_DATA_ADDR, 8'h20);
    endtask

    task automatic t_revert;
        wr(`PB_DIR_ADDR, 8'h40);
        chk({5'h00, pin_oe}, 8'h01);
        ext_en <= 3'b100;
        wr(`PB_SCR_ADDR, 8'h00);
        chk({5'h00, pin_oe}, 8'h02);
        chk({5'h00, pin_out & 3'b010}, 8'h02);
        chk({5'h00, pulldown_on}, 8'h05);
        rd(8'h3F, 8'h00);
    endtask

    // Reset in mid-run must leave the global pulldown disable in force
    task automatic t_reset_global;
        @(posedge core_clk);
        global_pulldown_disable <= 1'b1;
        rst_n                   <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        idle(2);
        chk({5'h00, pulldown_on}, 8'h00);
        chk({5'h00, pin_oe}, 8'h00);
        @(posedge core_clk);
        global_pulldown_disable <= 1'b0;
        idle(2);
        chk({5'h00, pulldown_on}, 8'h07);
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Whole run needs under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        {rst_n, reg_wr, reg_rd, global_pulldown_disable} = 4'h0;
        {serial_data_out, serial_clk_out} = 2'b00;
        {reg_addr, reg_wdata} = 16'h0000;
        {ext_en, ext_val} = 6'h00;
        {mismatches, samples_checked, cycles} = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        idle(2);
        t_reset();
        t_output();
        t_input();
        t_master();
        t_slave();
        t_revert();
        t_reset_global();
        results();
    end
endmodule
